// ===== design/vcl_pkg.sv
// Shared constants and carrier types for the colour lookup pixel path.
// Assumes a single 200 MHz clock and an APB slave with 32-bit data.
package vcl_pkg;

   // Table geometry.
   localparam int unsigned TAB_AW = 10;
   localparam int unsigned TAB_DW = 12;
   localparam int unsigned TAB_DEPTH = 1024;
   localparam logic [2:0] PART_MAX = 3'h6;

   // APB byte addresses.
   localparam int unsigned PADDR_W = 8;
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_CNT_LO = 8'h08;
   localparam logic [7:0] A_CNT_HI = 8'h0c;
   localparam logic [7:0] A_TAB_LO = 8'h10;
   localparam logic [7:0] A_TAB_HI = 8'h14;
   localparam logic [7:0] A_MIX0 = 8'h20;
   localparam logic [7:0] A_MIX3 = 8'h2c;

   // Every access waits this many cycles in the access phase.
   localparam logic [1:0] WAIT_LAST = 2'h2;
   localparam logic [1:0] WAIT_READ = 2'h1;

   // Reset values.
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [9:0] CNT_RST = 10'h000;

   // Default overlay planes.
   localparam logic [3:0] OV1_PLANE = 4'ha;
   localparam logic [3:0] OV2_PLANE = 4'hb;

   typedef enum logic [1:0] {
      MODE_HIGH,
      MODE_MED,
      MODE_LOW
   } vcl_mode_t;

   // Control word, bit 0 is mode[0].
   typedef struct packed {
      logic [3:0] ov2;
      logic [3:0] ov1;
      logic ov_custom;
      logic host_sel;
      logic [2:0] part;
      logic grey_post;
      logic [1:0] mode;
   } vcl_ctrl_t;

   // The four refresh memory lines of one pixel word.
   typedef struct packed {
      logic [11:0] a_even;
      logic [11:0] a_odd;
      logic [11:0] b_even;
      logic [11:0] b_odd;
   } vcl_lines_t;

   typedef struct packed {
      logic blank;
      logic sync;
      logic hdrive;
      logic vdrive;
      logic [1:0] cursor;
   } vcl_side_t;

   typedef struct packed {
      logic [3:0] red;
      logic [3:0] green;
      logic [3:0] blue;
      logic [7:0] grey;
      vcl_side_t side;
   } vcl_video_t;

   typedef struct packed {
      logic [11:0] colour;
      logic [7:0] grey;
   } vcl_mix_t;

endpackage

// ===== design/vcl_colour_path.sv
// Colour lookup pixel path: input reclock, element and field pick,
// partitioned lookup table, cursor and overlay mixing, APB registers.
// Assumes memory lines and sync signals arrive asynchronous to mclk.
`timescale 1ns/1ps

// Function
// - One lookup table of 1024 words of 12 bits, addressed by pixel data.
// - The host can write table entries and read them back.
// - Table output splits into 4-bit red, green and blue fields.
// - Grey output takes low pixel bits before or low table bits after.
// - Grey output uses pre-table data after reset.
// - Grey output is 8 bits wide, 256 levels.
// - Blanking, sync, horizontal and vertical drive are passed through.
// - Two cursors and two overlays are mixed into the outputs.
// - High mode uses all four memory lines per channel.
// - Medium mode uses field A lines only.
// - Low mode uses the field A even line only.
// - Element pick low selects even line, high selects odd.
// - Field pick low selects field A, high selects field B.
// - Selected pixel data is registered before table addressing.
// - Table address comes from counter during host access, else pixel.
// - Table may be split into 512 down to 16 entry tables.
// - Upper table address bits of a partition come from the counter.
// - Coded mix tables set cursor and overlay colour and grey.
// - Overlays come from planes 10 and 11 or two chosen planes.
// - Table source select is low in display, high for host access.
// - Table is written only while the low active strobe is asserted.
// - Counter writes load counter bits 0 to 9.
// - Address bit 2 marks low byte or high byte transfers.
module vcl_colour_path
   import vcl_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire vcl_lines_t mem_lines,
   input wire logic element_pick,
   input wire logic field_pick,
   input wire vcl_side_t side_in,
   output vcl_video_t video_out,
   output logic table_source_select,
   output logic table_write_strobe_n
);

   // Whole state of the block apart from the table memory and entry_q.
   // Pipeline, counted in edges from a pin change: two synchroniser
   // stages, the pick register, the table read beside the pre-table
   // and overlay stage, and the output register. The side signals walk
   // through registers of their own at every stage, so blanking, sync
   // and cursors reach the outputs on the same edge as their colour.
   // A stage added to one path must be added to the other, or the
   // cursor lands one pixel off.
   typedef struct packed {
      vcl_ctrl_t ctrl;
      logic [9:0] counter;
      logic [7:0] lo_byte;
      logic [1:0] wait_cnt;
      logic [31:0] rdata;
      vcl_mix_t [3:0] mix;
      vcl_lines_t lines1;
      vcl_lines_t lines2;
      vcl_side_t side1;
      vcl_side_t side2;
      logic [1:0] pick1;
      logic [1:0] pick2;
      logic [11:0] pix;
      vcl_side_t side_p;
      logic [7:0] pre;
      logic [1:0] ovl;
      vcl_side_t side_t;
      vcl_video_t video;
   } vcl_state_t;

   vcl_state_t s_q;
   vcl_state_t s_d;

   // The table itself is kept outside the state record: it is large,
   // has no reset and maps onto block memory.
   logic [TAB_DW-1:0] table_mem [TAB_DEPTH];
   logic [TAB_DW-1:0] entry_q;
   logic [TAB_AW-1:0] tab_addr;
   logic [TAB_AW-1:0] pixel_addr;
   logic tab_we;
   logic hit_tab;
   logic done;

   // Picks one line per mode; unused lines never reach the table.
   // Lines a mode leaves unused may carry anything, so the mode forces
   // the unused pick signal low rather than trusting it.
   function automatic logic [11:0] vcl_pick(
      input vcl_lines_t l,
      input logic e_in,
      input logic f_in,
      input logic [1:0] mode
   );
      logic e;
      logic f;
      e = e_in;
      f = f_in;
      case (vcl_mode_t'(mode))
         MODE_HIGH: begin
            e = e_in;
         end
         MODE_MED: begin
            f = 1'b0;
         end
         MODE_LOW: begin
            e = 1'b0;
            f = 1'b0;
         end
         default: begin
            e = e_in;
         end
      endcase
      case ({f, e})
         2'b00: vcl_pick = l.a_even;
         2'b01: vcl_pick = l.a_odd;
         2'b10: vcl_pick = l.b_even;
         default: vcl_pick = l.b_odd;
      endcase
   endfunction

   // Mask of the pixel bits that address within one partition.
   // Codes above the largest split clamp to it, so a stray control
   // value never leaves fewer than sixteen entries per table.
   function automatic logic [9:0] vcl_part_mask(input logic [2:0] part);
      logic [2:0] p;
      p = (part > PART_MAX) ? PART_MAX : part;
      vcl_part_mask = 10'h3ff >> p;
   endfunction

   // Reads one plane of a pixel word; indices above 11 read as zero.
   function automatic logic vcl_plane(
      input logic [11:0] pix,
      input logic [3:0] idx
   );
      logic [11:0] sh;
      sh = pix >> idx;
      vcl_plane = sh[0];
   endfunction

   // True for every register offset the bus decodes. Mixing words
   // must be word aligned; anything else answers with an error.
   function automatic logic vcl_mapped(input logic [7:0] a);
      vcl_mapped = (a == A_CTRL) || (a == A_CNT_LO) || (a == A_CNT_HI) ||
         (a == A_TAB_LO) || (a == A_TAB_HI) ||
         ((a >= A_MIX0) && (a <= A_MIX3) && (a[1:0] == 2'h0));
   endfunction

   // Bus decode and table addressing.
   // A partition keeps the low pixel bits and fills the upper ones
   // from the counter, so the host picks the active table by loading
   // the counter.
   always_comb begin
      hit_tab = psel && ((paddr == A_TAB_LO) || (paddr == A_TAB_HI));
      done = psel && penable && (s_q.wait_cnt == WAIT_LAST);
      tab_we = done && pwrite && (paddr == A_TAB_HI);
      pixel_addr = (s_q.pix[9:0] & vcl_part_mask(s_q.ctrl.part)) |
         (s_q.counter & ~vcl_part_mask(s_q.ctrl.part));
      // Switching the source during host access briefly disturbs the
      // displayed colour, exactly as a shared address selector would.
      table_source_select = s_q.ctrl.host_sel || hit_tab;
      tab_addr = table_source_select ? s_q.counter : pixel_addr;
   end

   // Handshake outputs are combinational so the answer lands in the
   // cycle after the last wait state. Read data comes from a register
   // and holds until the next access latches a new word.
   assign pready = done;
   assign pslverr = done && !vcl_mapped(paddr);
   assign prdata = s_q.rdata;
   assign table_write_strobe_n = !tab_we;
   assign video_out = s_q.video;

   // Table write port and registered read port.
   // The write always uses the counter, which the selector also routes
   // to the read port while the host holds the table.
   always_ff @(posedge mclk) begin
      if (tab_we) begin
         table_mem[s_q.counter] <= {pwdata[3:0], s_q.lo_byte};
      end
   end

   // Read data register is reset so outputs start from a known value.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         entry_q <= 12'h000;
      end else begin
         entry_q <= table_mem[tab_addr];
      end
   end

   // Next state of the register file and of the pixel pipeline.
   always_comb begin
      logic [31:0] rd;
      logic [1:0] mix_idx;
      logic mix_hit;
      vcl_mix_t m;
      logic [7:0] grey_src;
      rd = 32'h0000_0000;
      mix_idx = 2'h0;
      mix_hit = 1'b0;
      m = '0;
      grey_src = 8'h00;
      s_d = s_q;

      // Read mux; table reads see the entry the counter points at.
      // Entries come back one byte at a time, low then high, so a
      // byte-wide host fetches a whole entry in two transfers.
      case (paddr)
         A_CTRL: rd = {16'h0000, s_q.ctrl};
         A_CNT_LO: rd = {24'h000000, s_q.counter[7:0]};
         A_CNT_HI: rd = {30'h00000000, s_q.counter[9:8]};
         A_TAB_LO: rd = {24'h000000, entry_q[7:0]};
         A_TAB_HI: rd = {28'h0000000, entry_q[11:8]};
         default: begin
            if (vcl_mapped(paddr) && (paddr >= A_MIX0)) begin
               rd = {12'h000, s_q.mix[paddr[3:2]]};
            end
         end
      endcase

      // Each access waits two cycles so the table read can settle.
      if (psel && penable && !done) begin
         s_d.wait_cnt = s_q.wait_cnt + 2'h1;
         if (s_q.wait_cnt == WAIT_READ) begin
            s_d.rdata = rd;
         end
      end
      // A master that drops the access early must not leave a stale
      // count behind for the next transfer.
      if (!(psel && penable)) begin
         s_d.wait_cnt = 2'h0;
      end
      if (done) begin
         s_d.wait_cnt = 2'h0;
         if (pwrite) begin
            case (paddr)
               A_CTRL: s_d.ctrl = pwdata[15:0];
               A_CNT_LO: s_d.counter[7:0] = pwdata[7:0];
               A_CNT_HI: s_d.counter[9:8] = pwdata[1:0];
               A_TAB_LO: s_d.lo_byte = pwdata[7:0];
               A_TAB_HI: s_d.counter = s_q.counter + 10'h001;
               default: begin
                  if (vcl_mapped(paddr) && (paddr >= A_MIX0)) begin
                     s_d.mix[paddr[3:2]] = pwdata[19:0];
                  end
               end
            endcase
         end else if (paddr == A_TAB_HI) begin
            // Completing a high byte read steps to the next entry.
            s_d.counter = s_q.counter + 10'h001;
         end
      end

      // Two-flop synchronisers for the memory line, pick and side inputs.
      // Line words are not gray coded, so a word that changes near an
      // edge may show mixed bits for one pixel; the memory boards must
      // hold each word steady around the sampling edge.
      s_d.lines1 = mem_lines;
      s_d.lines2 = s_q.lines1;
      s_d.side1 = side_in;
      s_d.side2 = s_q.side1;
      s_d.pick1 = {field_pick, element_pick};
      s_d.pick2 = s_q.pick1;

      // Selected data is registered; blanking pulls it to all ones.
      s_d.pix = s_q.side2.blank ? 12'hfff :
         vcl_pick(s_q.lines2, s_q.pick2[0], s_q.pick2[1],
            s_q.ctrl.mode);
      s_d.side_p = s_q.side2;

      // Stage beside the table read carries the pre-table data along.
      s_d.pre = s_q.pix[7:0];
      if (s_q.ctrl.ov_custom) begin
         s_d.ovl = {vcl_plane(s_q.pix, s_q.ctrl.ov2),
            vcl_plane(s_q.pix, s_q.ctrl.ov1)};
      end else begin
         s_d.ovl = {vcl_plane(s_q.pix, OV2_PLANE),
            vcl_plane(s_q.pix, OV1_PLANE)};
      end
      s_d.side_t = s_q.side_p;

      // Cursors outrank overlays; cursor 1 outranks cursor 2.
      // A fixed order keeps the mix a single small mux instead of a
      // coded table per combination, at the cost of no blending.
      if (s_q.side_t.cursor[0]) begin
         mix_idx = 2'h0;
         mix_hit = 1'b1;
      end else if (s_q.side_t.cursor[1]) begin
         mix_idx = 2'h1;
         mix_hit = 1'b1;
      end else if (s_q.ovl[0]) begin
         mix_idx = 2'h2;
         mix_hit = 1'b1;
      end else if (s_q.ovl[1]) begin
         mix_idx = 2'h3;
         mix_hit = 1'b1;
      end
      m = s_q.mix[mix_idx];
      grey_src = s_q.ctrl.grey_post ? entry_q[7:0] : s_q.pre;

      // Output register keeps colour aligned with the sync signals.
      s_d.video.side = s_q.side_t;
      if (s_q.side_t.blank) begin
         s_d.video.red = 4'h0;
         s_d.video.green = 4'h0;
         s_d.video.blue = 4'h0;
         s_d.video.grey = 8'h00;
      end else if (mix_hit) begin
         s_d.video.red = m.colour[11:8];
         s_d.video.green = m.colour[7:4];
         s_d.video.blue = m.colour[3:0];
         s_d.video.grey = m.grey;
      end else begin
         s_d.video.red = entry_q[11:8];
         s_d.video.green = entry_q[7:4];
         s_d.video.blue = entry_q[3:0];
         s_d.video.grey = grey_src;
      end
   end

   // State register; control resets to pre-table grey, high mode.
   // The reset branch loads constants only; the table has no reset
   // and reads unknown until the host fills it.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '0;
         s_q.ctrl <= CTRL_RST;
         s_q.counter <= CNT_RST;
      end else begin
         s_q <= s_d;
      end
   end

endmodule // vcl_colour_path

// ===== tb/vcl_chk.sv
// Checker for the colour lookup path: bus timing, strobes, video pipe.
// Bound to vcl_colour_path and sees only its ports.
`timescale 1ns/1ps
module vcl_chk
   import vcl_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire vcl_side_t side_in,
   input wire vcl_video_t video_out,
   input wire logic table_source_select,
   input wire logic table_write_strobe_n
);
   // One clock domain, so clock and reset are given once here.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   // Two wait states, then the answer.
   sequence s_wait;
      !pready ##1 !pready ##1 pready;
   endsequence
   property p_wait;
      psel && $rose(penable) |-> s_wait;
   endproperty
   property p_pulse;
      pready |=> !pready;
   endproperty
   property p_err;
      pslverr |-> pready;
   endproperty
   property p_strb;
      !table_write_strobe_n |-> psel && penable && pready && pwrite
         && paddr == A_TAB_HI;
   endproperty
   property p_strb1;
      !table_write_strobe_n |=> table_write_strobe_n;
   endproperty
   property p_tss;
      psel && (paddr == A_TAB_LO || paddr == A_TAB_HI)
         |-> table_source_select;
   endproperty
   // The side signals travel the same five stages as the pixels.
   property p_side;
      video_out.side == $past(side_in, 5);
   endproperty
   property p_blank;
      video_out.side.blank |-> {video_out.red, video_out.green,
         video_out.blue, video_out.grey} == 20'h00000;
   endproperty
   property p_prd;
      !psel |=> $stable(prdata);
   endproperty
   a_wait: assert property (p_wait) else $error("pready mistimed");
   a_pulse: assert property (p_pulse) else $error("pready too long");
   a_err: assert property (p_err) else $error("lone pslverr");
   a_strb: assert property (p_strb) else $error("stray strobe");
   a_strb1: assert property (p_strb1) else $error("long strobe");
   a_tss: assert property (p_tss) else $error("source not host");
   a_side: assert property (p_side) else $error("side misaligned");
   a_blank: assert property (p_blank) else $error("blank leak");
   a_prd: assert property (p_prd) else $error("prdata moved");
endmodule // vcl_chk

bind vcl_colour_path vcl_chk i_vcl_chk (.mclk, .arst_n, .psel, .penable,
   .pwrite, .paddr, .prdata, .pready, .pslverr, .side_in, .video_out,
   .table_source_select, .table_write_strobe_n);

// ===== tb/vcl_mem_model.sv
// Refresh memory model: drives the four memory lines of one pixel word.
// Assumes the bench tells it the resolution mode in use.
`timescale 1ns/1ps
module vcl_mem_model
   import vcl_pkg::*;
(
   input wire logic mclk,
   input wire logic [1:0] mode,
   input wire vcl_lines_t want,
   output vcl_lines_t lines
);
   logic [11:0] junk_q = 12'h5a5;

   // Unused lines carry noise, so a path that reads them shows it.
   always_ff @(posedge mclk) junk_q <= junk_q + 12'h123;

   // Lines a mode leaves unused are not held at the last value.
   always_comb begin
      lines = want;
      if (mode == 2'h1 || mode == 2'h2) begin
         lines.b_even = junk_q;
         lines.b_odd = ~junk_q;
      end
      if (mode == 2'h2) lines.a_odd = junk_q ^ 12'h0f0;
   end
endmodule // vcl_mem_model

// ===== tb/tb.sv
// Testbench for the colour lookup path over APB and the video pins.
// Assumes the memory model drives the lines and a 200 MHz clock.
`timescale 1ns/1ps
module tb;
   import vcl_pkg::*;
   logic mclk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, element_pick = 1'b0, field_pick = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, tss, strb_n, e;
   logic [1:0] md = 2'h0;
   logic [11:0] px;
   logic [11:0] ent [1024];
   vcl_lines_t want = {12'h001, 12'h002, 12'h003, 12'h004}, lines;
   vcl_side_t side_in = '0;
   vcl_video_t video_out;
   int n_mismatch = 0, n_checks = 0;

   vcl_colour_path i_vcl_colour_path (.mclk, .arst_n, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .mem_lines(lines), .element_pick, .field_pick, .side_in,
      .video_out, .table_source_select(tss), .table_write_strobe_n(strb_n));
   vcl_mem_model i_vcl_mem_model (.mclk, .mode(md), .want, .lines);

   // 200 MHz clock.
   always #2.5 mclk = ~mclk;

   task automatic chk(input string s, input logic [31:0] x, g);
      n_checks++;
      if (g !== x) begin
         n_mismatch++;
         $display("Error %s exp %h got %h", s, x, g);
      end
   endtask

   // One APB transfer; the request holds until pready is seen high.
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait that never sees pready.
      do @(posedge mclk); while (pready !== 1'b1);
      r = prdata; e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task automatic cnt(input logic [9:0] a);
      apb(1'b1, A_CNT_LO, {24'h0, a[7:0]});
      apb(1'b1, A_CNT_HI, {30'h0, a[9:8]});
   endtask

   task automatic wt(input logic [9:0] a, input logic [11:0] v);
      cnt(a);
      apb(1'b1, A_TAB_LO, {24'h0, v[7:0]});
      apb(1'b1, A_TAB_HI, {28'h0, v[11:8]});
      ent[a] = v;
   endtask

   task automatic setc(input logic [7:0] v);
      apb(1'b1, A_CTRL, {24'h0, v});
      md <= v[1:0];
   endtask

   // Pick inputs change, then the pipe is given time to settle.
   task automatic vchk(input logic ef, ff, input logic [11:0] c,
         input logic [7:0] g);
      element_pick <= ef; field_pick <= ff;
      repeat (8) @(posedge mclk);
      chk("colour", {20'h0, c}, {20'h0, video_out.red, video_out.green,
         video_out.blue});
      chk("grey", {24'h0, g}, {24'h0, video_out.grey});
   endtask

   task results;
      $display("Counts: %0d checks, %0d mismatches", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // Watchdog well beyond the four hundred or so cycles the tests need.
   initial begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      results;
   end

   // Main sequence: registers, table access, then the video path.
   initial begin
      repeat (20) @(posedge mclk);
      arst_n <= 1'b1;
      apb(1'b0, A_CTRL, 32'h0);
      chk("ctrl", {16'h0, CTRL_RST}, r);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", 32'h1, {31'h0, e});
      wt(10'h001, 12'ha51); wt(10'h002, 12'h1c7);
      wt(10'h003, 12'h2e8); wt(10'h004, 12'h3f9);
      wt(10'h3ff, 12'hb6d); wt(10'h201, 12'h4c3);
      cnt(10'h3ff);
      apb(1'b0, A_TAB_LO, 32'h0);
      chk("tab_lo", 32'h6d, r);
      apb(1'b0, A_TAB_HI, 32'h0);
      chk("tab_hi", 32'hb, r);
      // Every mode against every element and field pick.
      for (int m = 0; m < 3; m++) begin
         setc(m[7:0]);
         for (int i = 0; i < 4; i++) begin
            px = m == 0 ? (i[1] ? (i[0] ? 12'h004 : 12'h003)
               : (i[0] ? 12'h002 : 12'h001))
               : m == 1 ? (i[0] ? 12'h002 : 12'h001) : 12'h001;
            vchk(i[0], i[1], ent[px[9:0]], px[7:0]);
         end
      end
      setc(8'h06);
      vchk(1'b0, 1'b0, ent[1], ent[1][7:0]);
      // Four 256-entry tables; the counter's top bits pick table two.
      want.a_even <= 12'h101;
      setc(8'h12);
      cnt(10'h200);
      vchk(1'b0, 1'b0, ent[10'h201], 8'h01);
      // Host select routes the counter to the table address.
      setc(8'h42);
      cnt(10'h004);
      vchk(1'b0, 1'b0, ent[4], 8'h01);
      apb(1'b1, A_MIX0, 32'h000abc5a);
      apb(1'b1, A_MIX0 + 8'h08, 32'h000def33);
      want.a_even <= 12'h401;
      setc(8'h02);
      vchk(1'b0, 1'b0, 12'hdef, 8'h33);
      // Custom overlay planes 9 and 8 replace the default planes.
      apb(1'b1, A_CTRL, 32'h00008982);
      want.a_even <= 12'h201;
      vchk(1'b0, 1'b0, 12'hdef, 8'h33);
      side_in <= 6'h01;
      vchk(1'b0, 1'b0, 12'habc, 8'h5a);
      side_in <= 6'h20;
      vchk(1'b0, 1'b0, 12'h000, 8'h00);
      chk("blank", 32'h1, {31'h0, video_out.side.blank});
      results;
   end
endmodule // tb
